/* File: inc/timer_pkg.sv */
// constants, register map and types shared by the multichannel timer
package timer_pkg;

	localparam int          ADDR_W          = 8;
	localparam int          CNT_W           = 16;
	localparam int          NUM_CH          = 4;
	localparam int          NUM_PHASE       = 3;
	localparam int          DT_W            = 8;
	localparam int          STAT_W          = 6;

	// register byte offsets
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_PRESCALE   = 8'h04;
	localparam logic [7:0]  ADDR_RELOAD     = 8'h08;
	localparam logic [7:0]  ADDR_COUNT      = 8'h0c;
	localparam logic [7:0]  ADDR_STATUS     = 8'h10;
	localparam logic [7:0]  ADDR_MASK       = 8'h14;
	localparam logic [7:0]  ADDR_CHMODE     = 8'h18;
	localparam logic [7:0]  ADDR_DEADTIME   = 8'h1c;
	localparam logic [7:0]  ADDR_CC_BASE    = 8'h20;
	localparam logic [7:0]  ADDR_WIDTH_BASE = 8'h30;

	// control register fields
	localparam int          CTRL_EN         = 0;
	localparam int          CTRL_DOWN       = 1;
	localparam int          CTRL_CENTER     = 2;
	localparam int          CTRL_SINGLE     = 3;
	localparam int          CTRL_COMPL      = 4;
	localparam int          CTRL_SRC_LO     = 5;
	localparam int          CTRL_TRIG_START = 7;
	localparam int          CTRL_SYNC_RST   = 8;
	localparam int          CTRL_W          = 9;

	// status and mask fields
	localparam int          STAT_UPDATE     = 0;
	localparam int          STAT_CH_LO      = 1;
	localparam int          STAT_TRIG       = 5;

	// reset values
	localparam logic [8:0]  CTRL_RESET      = 9'h000;
	localparam logic [15:0] PRESCALE_RESET  = 16'h0000;
	localparam logic [15:0] RELOAD_RESET    = 16'hffff;
	localparam logic [15:0] COUNT_RESET     = 16'h0000;
	localparam logic [15:0] CC_RESET        = 16'h0000;
	localparam logic [5:0]  STATUS_RESET    = 6'h00;
	localparam logic [5:0]  MASK_RESET      = 6'h00;
	localparam logic [15:0] CHMODE_RESET    = 16'h0000;
	localparam logic [7:0]  DEADTIME_RESET  = 8'h00;

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [1:0] {
		VAR_REDUCED  = 2'b00,
		VAR_FULL     = 2'b01,
		VAR_ADVANCED = 2'b10
	} variant_t;

	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'b00,
		SRC_EXTTRIG  = 2'b01,
		SRC_ENCODER  = 2'b10
	} clk_src_t;

	typedef enum logic [1:0] {
		CH_OFF     = 2'b00,
		CH_CAPTURE = 2'b01,
		CH_TOGGLE  = 2'b10,
		CH_PWM     = 2'b11
	} ch_mode_t;

	typedef enum logic {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} count_dir_t;

	typedef struct packed {
		logic     out_en;
		logic     polarity;
		ch_mode_t mode;
	} ch_cfg_t;

endpackage : timer_pkg

/* File: logic/deadtime_pair.sv */
// complementary output pair with dead-time insertion
module deadtime_pair (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// control
	input  wire logic              enable,
	input  wire logic [7:0]        dead_time,
	input  wire logic              ref_in,
	// outputs
	output logic                   hi_out,
	output logic                   lo_out
);
	import timer_pkg::*;

	logic       ref_prev_reg;
	logic [7:0] gap_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			ref_prev_reg <= 1'b0;
		end else begin
			ref_prev_reg <= ref_in;
		end
	end

	// both sides off across each switching edge
	always_ff @(posedge clk) begin
		if (reset || !enable) begin
			hi_out  <= 1'b0;
			lo_out  <= 1'b0;
			gap_reg <= DEADTIME_RESET;
		end else if (ref_in != ref_prev_reg) begin
			hi_out  <= 1'b0; // [RL8]
			lo_out  <= 1'b0;
			gap_reg <= dead_time;
		end else if (gap_reg != 8'h00) begin
			gap_reg <= gap_reg - 8'h01;
		end else begin
			hi_out  <= ref_in; // [RL7]
			lo_out  <= !ref_in;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_pair_exclusive: assert property (!(hi_out && lo_out)) // [RL8]
		else $error("both outputs of a pair active");
	a_dead_gap: assert property ((enable && ref_in != ref_prev_reg && dead_time != 8'h00
		&& $stable(enable)) |=> !hi_out && !lo_out ##1 !hi_out && !lo_out) // [RL8]
		else $error("dead time not inserted");

endmodule : deadtime_pair

/* File: logic/multichannel_pwm_timer.sv */
// multichannel pwm timer with axi4-lite register slave
//
// Overview of operation
// RL1: full variant counts up or down, auto-reloads, uses a 16-bit prescaler.
// RL2: reduced variant counts upward only, auto-reloads, own 16-bit prescaler; encoder mode still counts down there on reverse rotation.
// RL3: four channels, each separately capture, output compare or pwm.
// RL4: pwm supports edge-aligned and center-aligned counting, chosen by configuration.
// RL5: single-pulse mode produces one period then stops the counter.
// RL6: encoder mode counts up or down from two quadrature inputs.
// RL7: advanced variant drives three complementary output pairs, six outputs.
// RL8: each pair gets programmable dead-time so both never active together.
// RL9: external trigger input can clock the counter or start it.
// RL10: counter can be reset by a sync input and drives a chaining trigger.
// RL11: capture channels measure input pulse width between rising and falling edge.
// RL12: advanced variant without complementary mode behaves as general timer.
// RL13: prescaler divides by value plus one; counter wraps to reload bound.
module multichannel_pwm_timer #(
	parameter timer_pkg::variant_t VARIANT = timer_pkg::VAR_ADVANCED
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// axi4-lite write
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [7:0]        awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	// axi4-lite read
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [7:0]        araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	// pins
	input  wire logic [3:0]        cap_in,
	input  wire logic              ext_trig_in,
	input  wire logic              enc_a_in,
	input  wire logic              enc_b_in,
	input  wire logic              sync_in,
	output logic [3:0]             pwm_out,
	output logic [2:0]             pwm_hi_out,
	output logic [2:0]             pwm_lo_out,
	output logic                   trig_out,
	output logic                   irq
);
	import timer_pkg::*;

	logic [8:0]        ctrl_reg;
	logic [15:0]       prescale_reg;
	logic [15:0]       reload_reg;
	logic [15:0]       cnt_reg;
	logic [15:0]       cnt_next;
	logic [15:0]       psc_cnt_reg;
	logic [5:0]        status_reg;
	logic [5:0]        mask_reg;
	ch_cfg_t [3:0]     ch_cfg_reg;
	logic [7:0]        dead_time_reg;
	logic [15:0]       cc_reg [4];
	logic [15:0]       cap_val [4];
	logic [15:0]       width_val [4];
	logic [3:0]        ch_event;
	count_dir_t        dir_reg;
	count_dir_t        dir_next;
	logic              aw_held;
	logic              w_held;
	logic [7:0]        aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              do_write;
	logic [31:0]       wr_val;
	logic              etr_prev_reg;
	logic              sync_prev_reg;
	logic              enc_a_prev_reg;
	logic              enc_b_prev_reg;
	logic              etr_rise;
	logic              sync_rst;
	logic              enc_step;
	logic              enc_up;
	logic              psc_step;
	logic              tick;
	logic              step;
	logic              step_up;
	logic              update_evt;
	logic              center_on;
	logic              down_on;
	logic              compl_on;
	logic              cnt_wr;
	logic              ctrl_wr;
	clk_src_t          src;

	// register bus slave
	function automatic logic addr_ok(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= ADDR_WIDTH_BASE + 8'h0c;
	endfunction : addr_ok

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	assign awready  = !aw_held && !bvalid;
	assign wready   = !w_held && !bvalid;
	assign arready  = !rvalid;
	assign do_write = aw_held && w_held && !bvalid;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held     <= 1'b0;
			w_held      <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bvalid      <= 1'b0;
			bresp       <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held     <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				w_held     <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata  <= 32'h0000_0000;
			case (araddr)
				ADDR_CTRL:     rdata[8:0]  <= ctrl_reg;
				ADDR_PRESCALE: rdata[15:0] <= prescale_reg;
				ADDR_RELOAD:   rdata[15:0] <= reload_reg;
				ADDR_COUNT:    rdata[15:0] <= cnt_reg;
				ADDR_STATUS:   rdata[5:0]  <= status_reg;
				ADDR_MASK:     rdata[5:0]  <= mask_reg;
				ADDR_CHMODE:   rdata[15:0] <= ch_cfg_reg;
				ADDR_DEADTIME: rdata[7:0]  <= dead_time_reg;
				default: begin
					if (araddr[7:4] == ADDR_CC_BASE[7:4]) begin
						rdata[15:0] <= (ch_cfg_reg[araddr[3:2]].mode == CH_CAPTURE) ?
							cap_val[araddr[3:2]] : cc_reg[araddr[3:2]];
					end else if (araddr[7:4] == ADDR_WIDTH_BASE[7:4]) begin
						rdata[15:0] <= width_val[araddr[3:2]];
					end
				end
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	assign wr_val  = merge(32'h0000_0000, w_data_reg, w_strb_reg);
	assign cnt_wr  = do_write && aw_addr_reg == ADDR_COUNT;
	assign ctrl_wr = do_write && aw_addr_reg == ADDR_CTRL;

	always_ff @(posedge clk) begin
		if (reset) begin
			prescale_reg  <= PRESCALE_RESET;
			reload_reg    <= RELOAD_RESET;
			mask_reg      <= MASK_RESET;
			ch_cfg_reg    <= CHMODE_RESET;
			dead_time_reg <= DEADTIME_RESET;
			for (int i = 0; i < NUM_CH; i++) begin
				cc_reg[i] <= CC_RESET;
			end
		end else if (do_write) begin
			case (aw_addr_reg)
				ADDR_PRESCALE: prescale_reg  <= 16'(merge({16'h0000, prescale_reg}, w_data_reg, w_strb_reg));
				ADDR_RELOAD:   reload_reg    <= 16'(merge({16'h0000, reload_reg}, w_data_reg, w_strb_reg));
				ADDR_MASK:     mask_reg      <= wr_val[5:0];
				ADDR_CHMODE:   ch_cfg_reg    <= 16'(merge({16'h0000, ch_cfg_reg}, w_data_reg, w_strb_reg));
				ADDR_DEADTIME: dead_time_reg <= wr_val[7:0];
				default: begin
					if (aw_addr_reg[7:4] == ADDR_CC_BASE[7:4]) begin
						cc_reg[aw_addr_reg[3:2]] <= 16'(merge({16'h0000,
							cc_reg[aw_addr_reg[3:2]]}, w_data_reg, w_strb_reg));
					end
				end
			endcase
		end
	end

	// control: software write, single-pulse stop, trigger start
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg <= CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= wr_val[8:0];
		end else if (ctrl_reg[CTRL_SINGLE] && update_evt) begin
			ctrl_reg[CTRL_EN] <= 1'b0; // [RL5]
		end else if (ctrl_reg[CTRL_TRIG_START] && etr_rise) begin
			ctrl_reg[CTRL_EN] <= 1'b1; // [RL9]
		end
	end

	// pin edge detection
	always_ff @(posedge clk) begin
		if (reset) begin
			etr_prev_reg   <= 1'b0;
			sync_prev_reg  <= 1'b0;
			enc_a_prev_reg <= 1'b0;
			enc_b_prev_reg <= 1'b0;
		end else begin
			etr_prev_reg   <= ext_trig_in;
			sync_prev_reg  <= sync_in;
			enc_a_prev_reg <= enc_a_in;
			enc_b_prev_reg <= enc_b_in;
		end
	end

	assign src       = clk_src_t'(ctrl_reg[CTRL_SRC_LO +: 2]);
	assign etr_rise  = ext_trig_in && !etr_prev_reg;
	assign sync_rst  = ctrl_reg[CTRL_SYNC_RST] && sync_in && !sync_prev_reg; // [RL10]
	assign center_on = VARIANT != VAR_REDUCED && ctrl_reg[CTRL_CENTER]; // [RL2]
	assign down_on   = VARIANT != VAR_REDUCED && ctrl_reg[CTRL_DOWN]; // [RL2]
	assign compl_on  = VARIANT == VAR_ADVANCED && ctrl_reg[CTRL_COMPL]; // [RL12]
	assign enc_up    = enc_a_in ^ enc_b_prev_reg; // [RL6]
	assign enc_step  = ctrl_reg[CTRL_EN] && src == SRC_ENCODER &&
		((enc_a_in ^ enc_a_prev_reg) || (enc_b_in ^ enc_b_prev_reg)); // [RL6]
	assign psc_step  = ctrl_reg[CTRL_EN] && (src == SRC_INTERNAL ||
		(src == SRC_EXTTRIG && etr_rise)); // [RL9]
	assign tick      = psc_step && psc_cnt_reg >= prescale_reg; // [RL13]
	assign step      = tick || enc_step;
	assign step_up   = enc_step ? enc_up : (center_on ? dir_reg == DIR_UP : !down_on);

	// prescaler divides by value plus one
	always_ff @(posedge clk) begin
		if (reset || sync_rst || !ctrl_reg[CTRL_EN]) begin
			psc_cnt_reg <= PRESCALE_RESET;
		end else if (psc_step) begin
			psc_cnt_reg <= tick ? PRESCALE_RESET : psc_cnt_reg + 16'h0001; // [RL13]
		end
	end

	// counter next value: up, down, center and encoder
	always_comb begin
		cnt_next   = cnt_reg;
		dir_next   = dir_reg;
		update_evt = 1'b0;
		if (step) begin
			if (step_up) begin
				if (cnt_reg >= reload_reg) begin
					update_evt = 1'b1;
					if (center_on && !enc_step) begin
						dir_next = DIR_DOWN; // [RL4]
						cnt_next = cnt_reg - 16'h0001;
					end else begin
						cnt_next = COUNT_RESET; // [RL1] [RL13]
					end
				end else begin
					cnt_next = cnt_reg + 16'h0001;
				end
			end else begin
				if (cnt_reg == 16'h0000) begin
					update_evt = 1'b1;
					if (center_on && !enc_step) begin
						dir_next = DIR_UP; // [RL4]
						cnt_next = cnt_reg + 16'h0001;
					end else begin
						cnt_next = reload_reg; // [RL1]
					end
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_reg <= COUNT_RESET;
			dir_reg <= DIR_UP;
		end else if (cnt_wr) begin
			cnt_reg <= wr_val[15:0];
		end else if (sync_rst) begin
			cnt_reg <= COUNT_RESET; // [RL10]
			dir_reg <= DIR_UP;
		end else begin
			cnt_reg <= cnt_next;
			dir_reg <= dir_next;
		end
	end

	// chaining trigger to other timers
	always_ff @(posedge clk) begin
		if (reset) begin
			trig_out <= 1'b0;
		end else begin
			trig_out <= update_evt; // [RL10]
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge clk) begin
		if (reset) begin
			status_reg <= STATUS_RESET;
		end else begin
			status_reg <= (status_reg & ~((do_write && aw_addr_reg == ADDR_STATUS) ?
				wr_val[5:0] : 6'h00)) | {etr_rise, ch_event, update_evt};
		end
	end

	assign irq = |(status_reg & mask_reg);

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			timer_channel u_ch (
				.clk         (clk),
				.reset       (reset),
				.cfg         (ch_cfg_reg[g]),
				.count       (cnt_reg),
				.compare     (cc_reg[g]),
				.step        (step),
				.cap_in      (cap_in[g]),
				.oc_out      (pwm_out[g]),
				.event_pulse (ch_event[g]),
				.cap_val     (cap_val[g]),
				.width_val   (width_val[g])
			); // [RL3]
		end
		for (g = 0; g < NUM_PHASE; g++) begin : g_phase
			deadtime_pair u_dt (
				.clk       (clk),
				.reset     (reset),
				.enable    (compl_on),
				.dead_time (dead_time_reg),
				.ref_in    (pwm_out[g]),
				.hi_out    (pwm_hi_out[g]),
				.lo_out    (pwm_lo_out[g])
			); // [RL7] [RL8]
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_plain_up;
		tick && !enc_step && !center_on && !down_on && !cnt_wr && !sync_rst;
	endsequence
	sequence s_plain_down;
		tick && !enc_step && !center_on && down_on && !cnt_wr && !sync_rst;
	endsequence

	a_prescale_div: assert property ((tick && prescale_reg != 16'h0000 && !sync_rst && !do_write) // [RL13]
		|=> !tick) else $error("prescaler ticked twice in a row");
	a_upcount_wrap: assert property ((s_plain_up and cnt_reg >= reload_reg) // [RL1]
		|=> cnt_reg == 16'h0000 && status_reg[STAT_UPDATE]) else $error("up wrap wrong");
	a_downcount_wrap: assert property ((s_plain_down and cnt_reg == 16'h0000) // [RL1]
		|=> cnt_reg == $past(reload_reg)) else $error("down wrap wrong");
	a_upcount_step: assert property ((s_plain_up and cnt_reg < reload_reg) // [RL2]
		|=> cnt_reg == $past(cnt_reg) + 16'h0001) else $error("up step wrong");
	a_reduced_up: assert property (VARIANT == VAR_REDUCED |-> !down_on && !center_on) // [RL2]
		else $error("reduced variant counts down");
	a_center_turn: assert property ((tick && !enc_step && center_on && dir_reg == DIR_UP // [RL4]
		&& cnt_reg >= reload_reg && !cnt_wr && !sync_rst) |=> dir_reg == DIR_DOWN)
		else $error("center mode did not turn");
	a_single_stop: assert property ((ctrl_reg[CTRL_SINGLE] && update_evt && !ctrl_wr // [RL5]
		&& !ctrl_reg[CTRL_TRIG_START]) |=> !ctrl_reg[CTRL_EN] ##1 !tick)
		else $error("single pulse did not stop");
	a_encoder_count: assert property ((enc_step && enc_up && cnt_reg < reload_reg // [RL6]
		&& !cnt_wr && !sync_rst) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
		else $error("encoder count wrong");
	a_trig_start: assert property ((ctrl_reg[CTRL_TRIG_START] && etr_rise && !ctrl_wr // [RL9]
		&& !(ctrl_reg[CTRL_SINGLE] && update_evt)) |=> ctrl_reg[CTRL_EN])
		else $error("trigger did not start counter");
	a_sync_reset: assert property ((sync_rst && !cnt_wr) |=> cnt_reg == 16'h0000) // [RL10]
		else $error("sync did not reset counter");
	a_general_mode: assert property (!compl_on |=> pwm_hi_out == 3'b000 && pwm_lo_out == 3'b000) // [RL12]
		else $error("complementary outputs active in general mode");

endmodule : multichannel_pwm_timer

/* File: logic/timer_channel.sv */
// one capture / compare / pwm channel of the timer
module timer_channel (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// configuration and counter
	input  timer_pkg::ch_cfg_t     cfg,
	input  wire logic [15:0]       count,
	input  wire logic [15:0]       compare,
	input  wire logic              step,
	// pin side
	input  wire logic              cap_in,
	output logic                   oc_out,
	// results
	output logic                   event_pulse,
	output logic [15:0]            cap_val,
	output logic [15:0]            width_val
);
	import timer_pkg::*;

	logic cap_prev_reg;
	logic cap_rise;
	logic cap_fall;

	assign cap_rise = cap_in && !cap_prev_reg;
	assign cap_fall = !cap_in && cap_prev_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			cap_prev_reg <= 1'b0;
		end else begin
			cap_prev_reg <= cap_in;
		end
	end

	// capture on rise, width on fall
	always_ff @(posedge clk) begin
		if (reset) begin
			cap_val   <= CC_RESET;
			width_val <= CC_RESET;
		end else if (cfg.mode == CH_CAPTURE) begin
			if (cap_rise) begin
				cap_val <= count; // [RL3]
			end
			if (cap_fall) begin
				width_val <= count - cap_val; // [RL11]
			end
		end
	end

	// output waveform
	always_ff @(posedge clk) begin
		if (reset) begin
			oc_out <= 1'b0;
		end else begin
			case (cfg.mode)
				CH_PWM: begin
					oc_out <= cfg.out_en && ((count < compare) ^ cfg.polarity); // [RL4]
				end
				CH_TOGGLE: begin
					if (!cfg.out_en) begin
						oc_out <= 1'b0;
					end else if (step && count == compare) begin
						oc_out <= !oc_out; // [RL3]
					end
				end
				default: begin
					oc_out <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			event_pulse <= 1'b0;
		end else if (cfg.mode == CH_CAPTURE) begin
			event_pulse <= cap_rise;
		end else begin
			event_pulse <= (cfg.mode != CH_OFF) && step && count == compare;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_capture_store: assert property ((cfg.mode == CH_CAPTURE && cap_rise) |=> // [RL3]
		cap_val == $past(count)) else $error("capture value not stored");
	a_width_measure: assert property ((cfg.mode == CH_CAPTURE && cap_fall && !cap_rise
		&& $stable(cfg)) |=> width_val == $past(count) - $past(cap_val)) // [RL11]
		else $error("pulse width wrong");
	a_pwm_level: assert property ((cfg.mode == CH_PWM) |=> // [RL4]
		oc_out == ($past(cfg.out_en) && (($past(count) < $past(compare)) ^ $past(cfg.polarity))))
		else $error("pwm level wrong");

endmodule : timer_channel

/* File: verif/pin_model.sv */
// far-side pin model: capture source and quadrature encoder
module pin_model (
	// clock
	input  wire logic       clk,
	// pins toward the timer
	output logic [3:0]      cap_in,
	output logic            enc_a_in,
	output logic            enc_b_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cap_in = 4'h0;
		enc_a_in = 1'b0;
		enc_b_in = 1'b0;
	end
	// one high pulse of len clocks on capture input ch
	task automatic pulse(input int ch, input int len);
		@(posedge clk);
		cap_in[ch] <= 1'b1;
		repeat (len) @(posedge clk);
		cap_in[ch] <= 1'b0;
	endtask : pulse
	// full quadrature cycles, phase a leading, gap clocks per step
	task automatic spin(input int cycles, input int gap);
		for (int i = 1; i <= 4 * cycles; i++) begin
			repeat (gap) @(posedge clk);
			enc_a_in <= (i % 4 == 1) || (i % 4 == 2);
			enc_b_in <= (i % 4 == 2) || (i % 4 == 3);
		end
	endtask : spin
endmodule : pin_model

/* File: verif/test_multichannel_pwm_timer.sv */
// self-checking bench for the multichannel pwm timer
module test_multichannel_pwm_timer;
	timeunit 1ns;
	timeprecision 1ns;
	import timer_pkg::*;
	logic        clk, reset, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, trig_out, irq;
	logic        enc_a_in, enc_b_in, etr, sync;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb, cap_in, pwm_out;
	logic [1:0]  bresp, rresp, rs;
	logic [2:0]  pwm_hi_out, pwm_lo_out;
	int          errors, checked, r, c, n, h, t, k;
	logic [39:0] rst_tab [9] = '{{ADDR_CTRL, 32'h0}, {ADDR_PRESCALE, 32'h0},
		{ADDR_RELOAD, 32'h0000_ffff}, {ADDR_COUNT, 32'h0}, {ADDR_STATUS, 32'h0},
		{ADDR_MASK, 32'h0}, {ADDR_CHMODE, 32'h0}, {ADDR_DEADTIME, 32'h0}, {8'h40, 32'h0}};

	multichannel_pwm_timer multichannel_pwm_timer_i (.clk, .reset, .awvalid, .awready,
		.awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .cap_in, .ext_trig_in(etr),
		.enc_a_in, .enc_b_in, .sync_in(sync), .pwm_out, .pwm_hi_out, .pwm_lo_out,
		.trig_out, .irq);
	pin_model pin_model_i (.clk, .cap_in, .enc_a_in, .enc_b_in);

	always #50 clk = ~clk;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 0;
		while (!done) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			done = bvalid;
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rdreg(input logic [7:0] a);
		bit done;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 0;
		while (!done) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			done = rvalid;
			rd = rdata;
			rs = rresp;
		end
		rready <= 1'b0;
	endtask : rdreg

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	initial begin
		#2ms;
		errors++;
		complete_run();
	end

	initial begin
		{clk, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, etr, sync} = '0;
		reset = 1'b1;
		wstrb = 4'hf;
		errors = 0;
		checked = 0;
		void'($urandom(34236));
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		foreach (rst_tab[i]) begin
			rdreg(rst_tab[i][39:32]);
			chk("reset value", rst_tab[i][31:0], rd);
		end
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		// pwm duty: up at two prescales, down, center; channel 1 toggles
		r = 8 + $urandom % 32;
		c = 1 + $urandom % r;
		wr(ADDR_RELOAD, 32'(r));
		wr(ADDR_CC_BASE, 32'(c));
		wr(ADDR_CHMODE, 32'h00ab);
		for (int p = 0; p < 4; p++) begin
			h = 1 + (p == 1);
			k = (p == 3) ? 2 * r : r + 1;
			wr(ADDR_PRESCALE, 32'(h - 1));
			wr(ADDR_CTRL, 32'(p < 2 ? 1 : 2 * p - 1));
			repeat (2 * k * h) @(posedge clk);
			n = 0;
			t = 0;
			c = c + 0;
			repeat (4 * k * h) begin
				@(posedge clk);
				n += (pwm_out[0] === 1'b1);
				t += (trig_out === 1'b1);
				r = r + 0;
			end
			chk("pwm high cycles", 32'(4 * h * ((p == 3) ? 2 * c - 1 : c)), 32'(n));
			chk("chain trigger", 32'((p == 3) ? 8 : 4), 32'(t));
		end
		// update flag, mask and interrupt
		wr(ADDR_CTRL, 32'h0);
		rdreg(ADDR_STATUS);
		chk("update flag", 32'h1, rd & 32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(ADDR_MASK, 32'h1);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(ADDR_STATUS, 32'h003f);
		rdreg(ADDR_STATUS);
		chk("flags cleared", 32'h0, rd);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// capture pulse width
		wr(ADDR_RELOAD, 32'h0000_ffff);
		wr(ADDR_PRESCALE, 32'h0);
		wr(ADDR_CHMODE, 32'h0001);
		wr(ADDR_CTRL, 32'h0001);
		r = 3 + $urandom % 60;
		pin_model_i.pulse(0, r);
		repeat (4) @(posedge clk);
		rdreg(ADDR_WIDTH_BASE);
		chk("pulse width", 32'(r), rd);
		// quadrature encoder counting
		wr(ADDR_CTRL, 32'h0041);
		wr(ADDR_COUNT, 32'h0);
		r = 2 + $urandom % 10;
		pin_model_i.spin(r, 3);
		repeat (4) @(posedge clk);
		rdreg(ADDR_COUNT);
		chk("encoder count", 32'(4 * r), rd);
		// single pulse stops the counter
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_RELOAD, 32'h0005);
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_CTRL, 32'h0009);
		repeat (20) @(posedge clk);
		rdreg(ADDR_CTRL);
		chk("single pulse stop", 32'h0008, rd);
		// trigger start and sync reset
		wr(ADDR_CTRL, 32'h0180);
		etr <= 1'b1;
		repeat (2) @(posedge clk);
		rdreg(ADDR_CTRL);
		chk("trigger start", 32'h0181, rd);
		sync <= 1'b1;
		rdreg(ADDR_COUNT);
		chk("sync reset", 32'h0, rd);
		// complementary pair with dead-time
		wr(ADDR_RELOAD, 32'h0014);
		wr(ADDR_CC_BASE, 32'h000a);
		wr(ADDR_CHMODE, 32'h000b);
		wr(ADDR_DEADTIME, 32'h0003);
		wr(ADDR_CTRL, 32'h0011);
		n = 0;
		h = 0;
		repeat (100) begin
			@(posedge clk);
			n += ((pwm_hi_out[0] & pwm_lo_out[0]) === 1'b1);
			h += (pwm_hi_out[0] === 1'b1);
		end
		chk("pair overlap", 32'h0, 32'(n));
		chk("pair active", 32'h1, 32'(h > 0));
		complete_run();
	end
endmodule : test_multichannel_pwm_timer
